// ===== src/sfstl_pkg.sv
package sfstl_pkg;
   // Register byte offsets
   localparam logic [7:0] ADDR_CFG = 8'h00;
   localparam logic [7:0] ADDR_ACTIVE = 8'h04;
   localparam logic [7:0] ADDR_LIMITS = 8'h08;
   localparam logic [7:0] ADDR_TORQUE = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_IRQ_EN = 8'h14;
   localparam logic [7:0] ADDR_IRQ_CLR = 8'h18;
   localparam logic [7:0] ADDR_STATE = 8'h1C;
   // Configuration field positions
   localparam int DISP_LSB = 0;
   localparam int MODE_LSB = 8;
   localparam int TLSEL_LSB = 12;
   localparam int TRAV_LSB = 16;
   localparam int STOPSEL_LSB = 20;
   localparam int TQ2_LSB = 16;
   // Reset values of pending settings
   localparam logic [4:0] DISP_RST = 5'h01;
   localparam logic [2:0] MODE_RST = 3'h0;
   localparam logic [1:0] TLSEL_RST = 2'h1;
   localparam logic [1:0] TRAV_RST = 2'h1;
   localparam logic [1:0] STOPSEL_RST = 2'h0;
   localparam logic [15:0] TQ1_RST = 16'h012C;
   localparam logic [15:0] TQ2_RST = 16'h012C;
   // Codes
   localparam logic [2:0] MODE_POS = 3'h0;
   localparam logic [2:0] MODE_SPD = 3'h1;
   localparam logic [1:0] TL_SAME = 2'h1;
   localparam logic [1:0] TL_SPLIT = 2'h2;
   localparam logic [1:0] TL_SWITCH = 2'h3;
   localparam logic [1:0] TRAV_EN = 2'h0;
   localparam logic [1:0] TRAV_OFF = 2'h1;
   localparam logic [1:0] TRAV_ALARM = 2'h2;
   localparam logic [7:0] ALARM_TRAVEL = 8'h26;
   // Status bits
   localparam int ST_FWD_BLK = 0;
   localparam int ST_REV_BLK = 1;
   localparam int ST_ALARM = 2;
   localparam int NUM_EVT = 3;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   typedef enum logic [1:0] {
      SF_LOAD = 2'b00,
      SF_RUN = 2'b01
   } sfstl_state_e;
endpackage : sfstl_pkg

// ===== src/sfstl_top.sv
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Station number latched from switch after reset
// - Station number drives serial link address
// - Station number never affects motor control
// - Display selector 0-17, reserved codes passed on unflagged
// - Mode 0 pulse position, 1 internal speed
// - Limit select 1: first limit both ways
// - Limit select 2: first forward, second reverse
// - Limit select 3: switch input picks limit
// - Limit select 0: first limit both ways
// - Torque control: first limit both ways
// - Open forward input blocks forward only
// - Open reverse input blocks reverse only
// - Travel select 1 ignores both inputs
// - Blocked motion in travel select 0 stops per stop selection
// - Both inputs open raises alarm 38 in travel select 0
// - Travel select 2: either open alarms
// - Power-cycle settings act only after reset
module sfstl_top (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [3:0] stationSwitch,
   input wire logic forwardLimitInput,
   input wire logic reverseLimitInput,
   input wire logic gainLimitSwitchInput,
   input wire logic torqueControlActive,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [3:0] linkAddress,
   output logic [4:0] displayItem,
   output logic positionMode,
   output logic speedMode,
   output logic [15:0] forwardTorqueLimit,
   output logic [15:0] reverseTorqueLimit,
   output logic forwardBlocked,
   output logic reverseBlocked,
   output logic limitStopRequest,
   output logic [1:0] limitStopSelection,
   output logic [7:0] alarmCode,
   output logic irq
);
   import sfstl_pkg::*;

   sfstl_state_e state_r;
   // Pending settings; kept like non-volatile storage, untouched by reset
   logic [4:0] pDisp_r = DISP_RST;
   logic [2:0] pMode_r = MODE_RST;
   logic [1:0] pTl_r = TLSEL_RST;
   logic [1:0] pTrav_r = TRAV_RST;
   logic [1:0] pStop_r = STOPSEL_RST;
   logic [15:0] pTq1_r = TQ1_RST;
   logic [15:0] pTq2_r = TQ2_RST;
   // Active copies
   logic [3:0] station_r;
   logic [4:0] aDisp_r;
   logic [2:0] aMode_r;
   logic [1:0] aTl_r;
   logic [1:0] aTrav_r;
   logic [1:0] aStop_r;
   logic [15:0] aTq1_r;
   logic [15:0] aTq2_r;
   logic [NUM_EVT-1:0] status_r;
   logic [NUM_EVT-1:0] irqEn_r;
   logic [NUM_EVT-1:0] evt;
   logic fwdBlk;
   logic revBlk;
   logic alarmNow;
   logic [15:0] fwdTq;
   logic [15:0] revTq;

   // Write channel state
   logic awHeld_r;
   logic wHeld_r;
   logic [7:0] awAddr_r;
   logic [31:0] wData_r;
   logic [3:0] wStrb_r;
   logic doWrite;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return res;
   endfunction : merge

   function automatic logic mapped(input logic [7:0] a);
      return (a[1:0] == 2'b00) && (a <= ADDR_STATE);
   endfunction : mapped

   // Same field layout for pending and active settings
   function automatic logic [31:0] packCfg(input logic [4:0] disp, input logic [2:0] mode,
                                           input logic [1:0] tl, input logic [1:0] trav,
                                           input logic [1:0] stop);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[DISP_LSB +: 5] = disp;
      w[MODE_LSB +: 3] = mode;
      w[TLSEL_LSB +: 2] = tl;
      w[TRAV_LSB +: 2] = trav;
      w[STOPSEL_LSB +: 2] = stop;
      return w;
   endfunction : packCfg

   // Open contact blocks its direction unless limits are ignored
   function automatic logic blocks(input logic [1:0] sel, input logic contact);
      return (sel != TRAV_OFF) && !contact;
   endfunction : blocks

   logic [31:0] cfgWord;
   logic [31:0] tqWord;
   logic [31:0] cfgMerged;
   logic [31:0] tqMerged;
   logic [31:0] irqEnMerged;
   assign cfgWord = packCfg(pDisp_r, pMode_r, pTl_r, pTrav_r, pStop_r);
   assign tqWord = {pTq2_r, pTq1_r};
   // Byte lanes of a write laid over the current contents
   assign cfgMerged = merge(cfgWord, wData_r, wStrb_r);
   assign tqMerged = merge(tqWord, wData_r, wStrb_r);
   assign irqEnMerged = merge({29'h0, irqEn_r}, wData_r, wStrb_r);

   // Load active copies once after reset
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state_r <= SF_LOAD;
         station_r <= 4'h0;
         aDisp_r <= DISP_RST;
         aMode_r <= MODE_RST;
         aTl_r <= TLSEL_RST;
         aTrav_r <= TRAV_RST;
         aStop_r <= STOPSEL_RST;
         aTq1_r <= TQ1_RST;
         aTq2_r <= TQ2_RST;
      end else begin
         case (state_r)
            SF_LOAD: begin
               // Switch sampled once here; no bus path reaches it
               station_r <= stationSwitch;
               aDisp_r <= pDisp_r;
               aMode_r <= pMode_r;
               aTl_r <= pTl_r;
               aTrav_r <= pTrav_r;
               aStop_r <= pStop_r;
               aTq1_r <= pTq1_r;
               aTq2_r <= pTq2_r;
               state_r <= SF_RUN;
            end
            SF_RUN: state_r <= SF_RUN;
            default: state_r <= SF_LOAD;
         endcase
      end
   end

   // Torque limit selection
   // Reserved selector code keeps the first limit both ways
   always_comb begin
      fwdTq = aTq1_r;
      revTq = aTq1_r;
      if (!torqueControlActive) begin
         case (aTl_r)
            TL_SPLIT: revTq = aTq2_r;
            TL_SWITCH: begin
               if (gainLimitSwitchInput) begin
                  fwdTq = aTq2_r;
                  revTq = aTq2_r;
               end
            end
            default: ;
         endcase
      end
   end

   // Travel limits; input high means contact closed
   always_comb begin
      fwdBlk = blocks(aTrav_r, forwardLimitInput);
      revBlk = blocks(aTrav_r, reverseLimitInput);
      // Alarm mode trips on one open contact, enabled mode on both
      alarmNow = 1'b0;
      if (aTrav_r == TRAV_EN) begin
         alarmNow = fwdBlk && revBlk;
      end else if (aTrav_r == TRAV_ALARM) begin
         alarmNow = fwdBlk || revBlk;
      end
      evt = '0;
      evt[ST_FWD_BLK] = fwdBlk;
      evt[ST_REV_BLK] = revBlk;
      evt[ST_ALARM] = alarmNow;
   end

   // Power-cycle settings as seen from outside
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         linkAddress <= 4'h0;
         displayItem <= DISP_RST;
         positionMode <= 1'b1;
         speedMode <= 1'b0;
         limitStopSelection <= STOPSEL_RST;
      end else begin
         linkAddress <= station_r;
         displayItem <= aDisp_r;
         positionMode <= (aMode_r == MODE_POS);
         speedMode <= (aMode_r == MODE_SPD);
         limitStopSelection <= aStop_r;
      end
   end

   // Selected torque limits
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         forwardTorqueLimit <= TQ1_RST;
         reverseTorqueLimit <= TQ1_RST;
      end else begin
         forwardTorqueLimit <= fwdTq;
         reverseTorqueLimit <= revTq;
      end
   end

   // Travel-limit outputs
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         forwardBlocked <= 1'b0;
         reverseBlocked <= 1'b0;
         limitStopRequest <= 1'b0;
         alarmCode <= 8'h00;
      end else begin
         forwardBlocked <= fwdBlk;
         reverseBlocked <= revBlk;
         limitStopRequest <= (aTrav_r == TRAV_EN) && (fwdBlk || revBlk);
         alarmCode <= alarmNow ? ALARM_TRAVEL : 8'h00;
      end
   end

   // Sticky status; set wins over clear
   // Irq also sees live events, so it rises with the status bit
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         status_r <= '0;
         irq <= 1'b0;
      end else begin
         if (doWrite && awAddr_r == ADDR_IRQ_CLR) begin
            status_r <= (status_r & ~wData_r[NUM_EVT-1:0]) | evt;
         end else begin
            status_r <= status_r | evt;
         end
         irq <= |((status_r | evt) & irqEn_r);
      end
   end

   // AXI write path
   // Address and data taken in either order; refused until response taken
   assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         awHeld_r <= 1'b0;
         wHeld_r <= 1'b0;
         awAddr_r <= 8'h00;
         wData_r <= 32'h0000_0000;
         wStrb_r <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_r <= 1'b1;
            awAddr_r <= s_axi_awaddr[7:0];
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_r <= 1'b1;
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(awAddr_r) ? RESP_OKAY : RESP_SLVERR;
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Writable settings; no reset so they survive a power cycle
   always_ff @(posedge sys_clk) begin
      if (doWrite) begin
         case (awAddr_r)
            ADDR_CFG: begin
               pDisp_r <= cfgMerged[DISP_LSB +: 5];
               pMode_r <= cfgMerged[MODE_LSB +: 3];
               pTl_r <= cfgMerged[TLSEL_LSB +: 2];
               pTrav_r <= cfgMerged[TRAV_LSB +: 2];
               pStop_r <= cfgMerged[STOPSEL_LSB +: 2];
            end
            ADDR_TORQUE: begin
               pTq1_r <= tqMerged[15:0];
               pTq2_r <= tqMerged[TQ2_LSB +: 16];
            end
            default: ;
         endcase
      end
   end

   // Interrupt enables
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         irqEn_r <= '0;
      end else if (doWrite && awAddr_r == ADDR_IRQ_EN) begin
         irqEn_r <= irqEnMerged[NUM_EVT-1:0];
      end
   end

   // AXI read path
   // Unmapped offsets read as zero with an error response
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mapped(s_axi_araddr[7:0]) ? RESP_OKAY : RESP_SLVERR;
            case (s_axi_araddr[7:0])
               ADDR_CFG: s_axi_rdata <= cfgWord;
               ADDR_ACTIVE: s_axi_rdata <= packCfg(aDisp_r, aMode_r, aTl_r, aTrav_r, aStop_r);
               ADDR_LIMITS: s_axi_rdata <= {16'h0000, alarmCode, 4'h0, station_r};
               ADDR_TORQUE: s_axi_rdata <= tqWord;
               ADDR_STATUS: s_axi_rdata <= {29'h0, status_r};
               ADDR_IRQ_EN: s_axi_rdata <= {29'h0, irqEn_r};
               ADDR_STATE: s_axi_rdata <= {16'h0000, revTq[7:0], 3'h0, fwdBlk, revBlk,
                                           alarmNow, state_r};
               default: s_axi_rdata <= 32'h0000_0000;
            endcase
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end
endmodule : sfstl_top
`default_nettype wire

// ===== verification/sfstl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module sfstl_assertions (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic torqueControlActive,
   input wire logic s_axi_awready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [3:0] linkAddress,
   input wire logic [4:0] displayItem,
   input wire logic positionMode,
   input wire logic speedMode,
   input wire logic [15:0] forwardTorqueLimit,
   input wire logic [15:0] reverseTorqueLimit,
   input wire logic forwardBlocked,
   input wire logic reverseBlocked,
   input wire logic limitStopRequest,
   input wire logic [1:0] limitStopSelection,
   input wire logic [7:0] alarmCode
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   chk_alarm_value: assert property (alarmCode == 8'h00 || alarmCode == 8'h26)
      else $error("alarm code invalid");
   chk_stop_cause: assert property (limitStopRequest |-> forwardBlocked || reverseBlocked)
      else $error("stop without block");
   chk_both_alarm: assert property (
      forwardBlocked && reverseBlocked && limitStopRequest |-> alarmCode == 8'h26)
      else $error("both open without alarm");
   chk_mode_onehot: assert property (!(positionMode && speedMode))
      else $error("two modes active");
   chk_settings_hold: assert property ($past(nrst, 4) |->
      $stable({linkAddress, displayItem, positionMode, speedMode, limitStopSelection}))
      else $error("setting changed in run");
   chk_torque_same: assert property (
      torqueControlActive [*2] |-> forwardTorqueLimit == reverseTorqueLimit)
      else $error("torque control limits differ");
   chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped");
   chk_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("awready during response");
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   cover property (forwardBlocked && limitStopRequest);
   cover property (alarmCode == 8'h26);
   cover property (speedMode);
endmodule : sfstl_assertions
bind sfstl_top sfstl_assertions chk (.sys_clk, .nrst, .torqueControlActive, .s_axi_awready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid, .s_axi_rready, .linkAddress, .displayItem, .positionMode, .speedMode,
   .forwardTorqueLimit, .reverseTorqueLimit, .forwardBlocked, .reverseBlocked,
   .limitStopRequest, .limitStopSelection, .alarmCode);
`default_nettype wire

// ===== verification/sfstl_limit_model.sv
`timescale 1ns/1ps
`default_nettype none
module sfstl_limit_model #(
   parameter int DLY = 1
) (
   input wire logic sys_clk,
   input wire logic fwdOpen,
   input wire logic revOpen,
   input wire logic gainClosed,
   output logic forwardLimitInput,
   output logic reverseLimitInput,
   output logic gainLimitSwitchInput
);
   // Contacts move DLY cycles after the request; no motion commands issued
   logic [3*DLY-1:0] contact_r = '1;
   always_ff @(posedge sys_clk) begin
      contact_r <= (contact_r << 3) | {!fwdOpen, !revOpen, gainClosed};
   end
   // Closed contact reads high, open reads low
   assign forwardLimitInput = contact_r[3*DLY-1];
   assign reverseLimitInput = contact_r[3*DLY-2];
   assign gainLimitSwitchInput = contact_r[3*DLY-3];
endmodule : sfstl_limit_model
`default_nettype wire

// ===== verification/servo_function_select_and_travel_limit_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("BAD %s exp %0h got %0h", nm, e, g); end end
module servo_function_select_and_travel_limit_tb;
   import sfstl_pkg::*;
   logic sys_clk, nrst = 0, torqueControlActive = 0, fwdOpen = 0, revOpen = 0, gainClosed = 0;
   logic [3:0] stationSwitch = 4'h0, s_axi_wstrb = 4'hF, linkAddress;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, d;
   logic [1:0] s_axi_bresp, s_axi_rresp, limitStopSelection, r, b;
   logic s_axi_rvalid, positionMode, speedMode, forwardBlocked, reverseBlocked, irq;
   logic limitStopRequest, forwardLimitInput, reverseLimitInput, gainLimitSwitchInput;
   logic [4:0] displayItem;
   logic [15:0] forwardTorqueLimit, reverseTorqueLimit;
   logic [7:0] alarmCode;
   int mismatches = 0, n_checks = 0;
   sfstl_top uut (.sys_clk, .nrst, .stationSwitch, .forwardLimitInput, .reverseLimitInput,
      .gainLimitSwitchInput, .torqueControlActive, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .linkAddress, .displayItem,
      .positionMode, .speedMode, .forwardTorqueLimit, .reverseTorqueLimit, .forwardBlocked,
      .reverseBlocked, .limitStopRequest, .limitStopSelection, .alarmCode, .irq);
   sfstl_limit_model #(.DLY(2)) host (.sys_clk, .fwdOpen, .revOpen, .gainClosed,
      .forwardLimitInput, .reverseLimitInput, .gainLimitSwitchInput);
   initial begin
      sys_clk = 0;
      forever #4 sys_clk = ~sys_clk;
   end
   task automatic test_done();
      if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : test_done
   initial begin
      #400000;
      mismatches++;
      test_done();
   end
   // Power cycle: settings taken over on release
   task automatic rst(input logic [3:0] s);
      @(posedge sys_clk);
      stationSwitch <= s;
      nrst <= 1'b0;
      repeat (8) @(posedge sys_clk);
      nrst <= 1'b1;
      repeat (4) @(posedge sys_clk);
   endtask : rst
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge sys_clk);
      s_axi_awaddr <= {24'h0, a};
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      b = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
      @(posedge sys_clk);
      s_axi_araddr <= {24'h0, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      v = s_axi_rdata;
      e = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
   task automatic contacts(input logic f, input logic v, input logic g);
      @(posedge sys_clk);
      fwdOpen <= f;
      revOpen <= v;
      gainClosed <= g;
      repeat (5) @(posedge sys_clk);
   endtask : contacts
   task automatic t_defaults();
      `CK("link", 4'hA, linkAddress)
      `CK("disp", DISP_RST, displayItem)
      `CK("pos", 1'b1, positionMode)
      `CK("tq1", TQ1_RST, forwardTorqueLimit)
      contacts(1, 1, 0);
      `CK("ignore", 11'h000, {forwardBlocked, reverseBlocked, limitStopRequest, alarmCode})
      contacts(0, 0, 0);
   endtask : t_defaults
   task automatic t_pending();
      wr(ADDR_CFG, 32'h0020_2111);
      `CK("bresp", RESP_OKAY, b)
      wr(ADDR_TORQUE, 32'h0200_0100);
      `CK("dispHeld", DISP_RST, displayItem)
      `CK("tqHeld", TQ1_RST, reverseTorqueLimit)
      rd(8'h20, d, r);
      `CK("unmapped", RESP_SLVERR, r)
      wr(8'h20, 32'hFFFF_FFFF);
      `CK("wrUnmapped", RESP_SLVERR, b)
      rst(4'h5);
      `CK("link", 4'h5, linkAddress)
      `CK("disp", 5'h11, displayItem)
      `CK("mode", 2'b01, {positionMode, speedMode})
      `CK("split", 32'h0200_0100, {reverseTorqueLimit, forwardTorqueLimit})
      `CK("stopSel", 2'h2, limitStopSelection)
      rd(ADDR_ACTIVE, d, r);
      `CK("active", 32'h0020_2111, d)
   endtask : t_pending
   task automatic t_travel();
      wr(ADDR_IRQ_EN, 32'h7);
      contacts(1, 0, 0);
      `CK("fwdOpen", 4'hB, {forwardBlocked, reverseBlocked, limitStopRequest, irq})
      contacts(0, 0, 0);
      rd(ADDR_STATUS, d, r);
      `CK("sticky", 32'h1, d)
      wr(ADDR_IRQ_CLR, 32'h7);
      rd(ADDR_STATUS, d, r);
      `CK("cleared", 32'h0, d)
      `CK("irqLow", 1'b0, irq)
      wr(ADDR_IRQ_EN, 32'h0);
      contacts(0, 1, 0);
      `CK("revOpen", 4'h6, {forwardBlocked, reverseBlocked, limitStopRequest, irq})
      contacts(1, 1, 0);
      `CK("bothOpen", 8'h26, alarmCode)
      contacts(0, 0, 0);
      `CK("noAlarm", 8'h00, alarmCode)
   endtask : t_travel
   task automatic t_torque();
      logic [15:0] ef [4] = '{16'h0100, 16'h0100, 16'h0100, 16'h0200};
      logic [15:0] er [4] = '{16'h0100, 16'h0100, 16'h0200, 16'h0200};
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_CFG, 32'h0002_0000 | (i << 12));
         rst(i[3:0]);
         contacts(0, 0, 1);
         `CK("tqFwd", ef[i], forwardTorqueLimit)
         `CK("tqRev", er[i], reverseTorqueLimit)
      end
      contacts(0, 0, 0);
      `CK("gainOpen", 16'h0100, reverseTorqueLimit)
      torqueControlActive <= 1'b1;
      contacts(0, 0, 1);
      `CK("tqCtl", 32'h0100_0100, {reverseTorqueLimit, forwardTorqueLimit})
      torqueControlActive <= 1'b0;
      contacts(0, 1, 0);
      `CK("oneOpen", 8'h26, alarmCode)
      contacts(0, 0, 0);
   endtask : t_torque
   initial begin
      rst(4'hA);
      t_defaults();
      t_pending();
      t_travel();
      t_torque();
      test_done();
   end
endmodule : servo_function_select_and_travel_limit_tb
`default_nettype wire
